// File: hdl/ser_link_pkg.sv
/*
 * shared constants of the serializer input and power control block:
 * register offsets, field positions, reset values, bus answer codes
 * and strap address layout.
 * assumes a 32-bit axi4-lite register bus and a 100 MHz system clock.
 */
package ser_link_pkg;
    // widths of the parallel word, control group, target address and strap code
    localparam int DATA_W = 24;
    localparam int CTRL_W = 3;
    localparam int ADDR_W = 7;
    localparam int STRAP_W = 3;

    // register byte offsets
    localparam logic [3:0] CFG_OFS = 4'h0;
    localparam logic [3:0] STATUS_OFS = 4'h4;
    localparam logic [3:0] CAPTURE_OFS = 4'h8;

    // configuration register fields
    localparam int EDGE_OVR_BIT = 0;
    localparam int EDGE_VAL_BIT = 1;
    localparam int SWING_OVR_BIT = 2;
    localparam int SWING_VAL_BIT = 3;
    localparam int CFG_W = 4;
    localparam logic [CFG_W-1:0] CFG_RESET = 4'h0;

    // status register fields
    localparam int ST_POWER_BIT = 0;
    localparam int ST_EDGE_BIT = 1;
    localparam int ST_SWING_BIT = 2;
    localparam int ST_I2C_BIT = 3;
    localparam int ST_ADDR_LSB = 4;

    // axi answer codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // target address: strap code lands in the low bits of this base
    localparam logic [ADDR_W-1:0] STRAP_ADDR_BASE = 7'h28;

    // two-wire bus: bits per address byte
    localparam logic [3:0] I2C_ADDR_BITS = 4'h8;
endpackage : ser_link_pkg

// File: hdl/sync_stage.sv
/*
 * two flip-flop synchroniser for levels, any width.
 * assumes each bit is a level (or a toggle) that stays stable long
 * enough to be seen by the destination clock.
 */
`timescale 1ns/10ps
module sync_stage #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clock,
    input wire logic enable,
    input wire logic reset,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r; // first stage, read only by q
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] q_nxt;

    // next values: shift one stage per enabled edge
    always_comb begin
        meta_nxt = meta_r;
        q_nxt = q;
        if (enable) begin
            meta_nxt = d;
            q_nxt = meta_r;
        end
    end

    // registers, constant on reset
    always_ff @(posedge clock) begin
        if (reset) begin
            meta_r <= INIT;
            q <= INIT;
        end else begin
            meta_r <= meta_nxt;
            q <= q_nxt;
        end
    end
endmodule : sync_stage

// File: hdl/serializer_input_and_power_control.sv
/*
 * pin-level control of a parallel-to-serial transmitter: power-down,
 * capture edge select, swing select, strap target address, a small
 * two-wire address responder and an axi4-lite register slave.
 * assumes parallel_strobe_in is the source clock, free running, and
 * that data and control pins are launched on that clock.
 */
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
module serializer_input_and_power_control
    import ser_link_pkg::*;
#(
    parameter int DW = DATA_W,
    parameter int CW = CTRL_W
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic enable,
    // pins
    input wire logic power_down_n,
    input wire logic strobe_edge_select,
    input wire logic swing_select,
    input wire logic [STRAP_W-1:0] target_address_strap,
    input wire logic parallel_strobe_in,
    input wire logic [DW-1:0] data_in,
    input wire logic [CW-1:0] ctrl_in,
    input wire logic config_scl,
    input wire logic config_sda_in,
    output logic config_sda_out,
    output logic config_sda_oe,
    // towards serial core and analog
    output logic serial_p,
    output logic serial_n,
    output logic pll_enable,
    output logic swing_large,
    output logic [ADDR_W-1:0] target_address,
    output logic [DW-1:0] tx_data,
    output logic [CW-1:0] tx_ctrl,
    output logic tx_valid,
    // axi4-lite slave
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int WW = DW + CW; // captured word width

    // system-domain pin synchronisers
    logic [STRAP_W+4:0] pins_s;
    logic pwr_s, edge_pin_s, swing_pin_s, scl_s, sda_s;
    logic [STRAP_W-1:0] strap_s;
    sync_stage #(.WIDTH(STRAP_W + 5)) u_pin_sync (
        .clock(clock), .enable(enable), .reset(reset),
        .d({target_address_strap, config_sda_in, config_scl, swing_select,
            strobe_edge_select, power_down_n}),
        .q(pins_s)
    );
    assign {strap_s, sda_s, scl_s, swing_pin_s, edge_pin_s, pwr_s} = pins_s;

    // configuration, strap and output state
    logic [CFG_W-1:0] cfg_r, cfg_nxt;
    logic strap_pend_r, strap_pend_nxt;
    logic [ADDR_W-1:0] addr_nxt;
    logic pll_nxt, swing_nxt, eff_edge;
    logic wr_do;
    logic [31:0] wr_data_r;
    logic [3:0] wr_addr_r;
    logic [3:0] wr_strb_r;

    // capture edge follows the register when overridden, else the pin
    assign eff_edge = cfg_r[EDGE_OVR_BIT] ? cfg_r[EDGE_VAL_BIT] : edge_pin_s;

    // next configuration; power-down returns it to reset
    always_comb begin
        cfg_nxt = cfg_r;
        strap_pend_nxt = strap_pend_r;
        addr_nxt = target_address;
        pll_nxt = pwr_s;
        swing_nxt = cfg_r[SWING_OVR_BIT] ? cfg_r[SWING_VAL_BIT] : swing_pin_s;
        if (!pwr_s) begin
            cfg_nxt = CFG_RESET;
            strap_pend_nxt = 1'b1;
        end else begin
            if (wr_do && wr_addr_r == CFG_OFS && wr_strb_r[0]) begin
                cfg_nxt = wr_data_r[CFG_W-1:0];
            end
            if (strap_pend_r) begin
                // strap level sampled after reset or power-down release
                addr_nxt = STRAP_ADDR_BASE | {{(ADDR_W-STRAP_W){1'b0}}, strap_s};
                strap_pend_nxt = 1'b0;
            end
        end
    end

    // configuration registers
    always_ff @(posedge clock) begin
        if (reset) begin
            cfg_r <= CFG_RESET;
            strap_pend_r <= 1'b1;
            target_address <= STRAP_ADDR_BASE;
            pll_enable <= 1'b0;
            swing_large <= 1'b0;
        end else if (enable) begin
            cfg_r <= cfg_nxt;
            strap_pend_r <= strap_pend_nxt;
            target_address <= addr_nxt;
            pll_enable <= pll_nxt;
            swing_large <= swing_nxt;
        end
    end

    // link-domain synchronisers: reset, enable, power, edge choice
    logic [3:0] link_s;
    logic link_rst, link_en, pwr_l, edge_l;
    sync_stage #(.WIDTH(4), .INIT(4'h1)) u_link_sync (
        .clock(parallel_strobe_in), .enable(1'b1), .reset(1'b0),
        .d({eff_edge, pwr_s, enable, reset}),
        .q(link_s)
    );
    assign {edge_l, pwr_l, link_en, link_rst} = link_s;

    // falling-edge capture of the pins
    logic [WW-1:0] fall_r;
    always_ff @(negedge parallel_strobe_in) begin
        fall_r <= {ctrl_in, data_in};
    end

    // captured word and leg drive, link domain
    logic [WW-1:0] word_nxt;
    logic valid_nxt, p_nxt, n_nxt;
    logic [WW-1:0] hold_r, hold_nxt;
    logic req_r, req_nxt, ack_l;
    always_comb begin
        word_nxt = {tx_ctrl, tx_data};
        valid_nxt = 1'b0;
        p_nxt = 1'b1;
        n_nxt = 1'b1;
        hold_nxt = hold_r;
        req_nxt = req_r;
        if (pwr_l) begin
            word_nxt = edge_l ? {ctrl_in, data_in} : fall_r;
            valid_nxt = 1'b1;
            p_nxt = ^word_nxt;
            n_nxt = ~p_nxt;
            if (req_r == ack_l) begin
                // previous copy taken: post the new word to the system side
                hold_nxt = word_nxt;
                req_nxt = ~req_r;
            end
        end
    end

    always_ff @(posedge parallel_strobe_in) begin
        if (link_rst) begin
            tx_data <= '0;
            tx_ctrl <= '0;
            tx_valid <= 1'b0;
            serial_p <= 1'b1;
            serial_n <= 1'b1;
            hold_r <= '0;
            req_r <= 1'b0;
        end else if (link_en) begin
            {tx_ctrl, tx_data} <= word_nxt;
            tx_valid <= valid_nxt;
            serial_p <= p_nxt;
            serial_n <= n_nxt;
            hold_r <= hold_nxt;
            req_r <= req_nxt;
        end
    end

    // toggle handshake: request into system, acknowledge back
    logic req_s, ack_r, ack_nxt;
    logic [WW-1:0] cap_r, cap_nxt;
    sync_stage #(.WIDTH(1)) u_req_sync (
        .clock(clock), .enable(enable), .reset(reset), .d(req_r), .q(req_s)
    );
    sync_stage #(.WIDTH(1)) u_ack_sync (
        .clock(parallel_strobe_in), .enable(link_en), .reset(link_rst),
        .d(ack_r), .q(ack_l)
    );

    // copy the stable held word when a new request is seen
    always_comb begin
        cap_nxt = cap_r;
        ack_nxt = ack_r;
        if (req_s != ack_r) begin
            cap_nxt = hold_r;
            ack_nxt = req_s;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            cap_r <= '0;
            ack_r <= 1'b0;
        end else if (enable) begin
            cap_r <= cap_nxt;
            ack_r <= ack_nxt;
        end
    end

    // two-wire address responder
    typedef enum logic [1:0] {I_IDLE, I_ADDR, I_ACK, I_SKIP} i2c_state_t;
    i2c_state_t i2c_r, i2c_nxt;
    logic scl_d_r, sda_d_r;
    logic [7:0] sh_r, sh_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic oe_nxt, scl_rise, scl_fall, i2c_start, i2c_stop, addr_hit;
    assign scl_rise = scl_s && !scl_d_r;
    assign scl_fall = !scl_s && scl_d_r;
    assign i2c_start = scl_s && scl_d_r && sda_d_r && !sda_s;
    assign i2c_stop = scl_s && scl_d_r && !sda_d_r && sda_s;
    assign addr_hit = sh_r[7:1] == target_address;

    // bit walk: shift address on rising clock, answer after the 8th bit
    always_comb begin
        i2c_nxt = i2c_r;
        sh_nxt = sh_r;
        bit_nxt = bit_r;
        oe_nxt = config_sda_oe;
        if (!pwr_s || i2c_stop) begin
            i2c_nxt = I_IDLE;
            oe_nxt = 1'b0;
        end else if (i2c_start) begin
            i2c_nxt = I_ADDR;
            bit_nxt = 4'h0;
            oe_nxt = 1'b0;
        end else begin
            case (i2c_r)
                I_ADDR: begin
                    if (scl_rise) begin
                        sh_nxt = {sh_r[6:0], sda_s};
                        bit_nxt = bit_r + 4'h1;
                    end else if (scl_fall && bit_r == I2C_ADDR_BITS) begin
                        i2c_nxt = addr_hit ? I_ACK : I_SKIP;
                        oe_nxt = addr_hit;
                    end
                end
                I_ACK: begin
                    if (scl_fall) begin
                        i2c_nxt = I_SKIP;
                        oe_nxt = 1'b0;
                    end
                end
                I_SKIP: oe_nxt = 1'b0;
                default: i2c_nxt = I_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            i2c_r <= I_IDLE;
            sh_r <= 8'h00;
            bit_r <= 4'h0;
            config_sda_oe <= 1'b0;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else if (enable) begin
            i2c_r <= i2c_nxt;
            sh_r <= sh_nxt;
            bit_r <= bit_nxt;
            config_sda_oe <= oe_nxt;
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end
    assign config_sda_out = 1'b0; // open drain: only ever pulls low

    // axi4-lite write side: address and data taken in either order
    logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt, bvalid_nxt;
    logic [31:0] wd_nxt;
    logic [3:0] wa_nxt, ws_nxt;
    logic [1:0] bresp_nxt;
    assign s_axi_awready = !aw_full_r && !s_axi_bvalid;
    assign s_axi_wready = !w_full_r && !s_axi_bvalid;
    assign wr_do = aw_full_r && w_full_r && !s_axi_bvalid;

    always_comb begin
        aw_full_nxt = aw_full_r;
        w_full_nxt = w_full_r;
        wa_nxt = wr_addr_r;
        wd_nxt = wr_data_r;
        ws_nxt = wr_strb_r;
        bvalid_nxt = s_axi_bvalid;
        bresp_nxt = s_axi_bresp;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_full_nxt = 1'b1;
            wa_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_full_nxt = 1'b1;
            wd_nxt = s_axi_wdata;
            ws_nxt = s_axi_wstrb;
        end
        if (wr_do) begin
            aw_full_nxt = 1'b0;
            w_full_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = (wr_addr_r == CFG_OFS || wr_addr_r == STATUS_OFS ||
                         wr_addr_r == CAPTURE_OFS) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
    end

    // axi4-lite read side: answer one cycle after the address
    logic rvalid_nxt;
    logic [31:0] rdata_nxt;
    logic [1:0] rresp_nxt;
    assign s_axi_arready = !s_axi_rvalid;

    always_comb begin
        rvalid_nxt = s_axi_rvalid;
        rdata_nxt = s_axi_rdata;
        rresp_nxt = s_axi_rresp;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = RESP_OKAY;
            case (s_axi_araddr)
                CFG_OFS: rdata_nxt = {{(32-CFG_W){1'b0}}, cfg_r};
                STATUS_OFS: rdata_nxt = {{(32-ST_ADDR_LSB-ADDR_W){1'b0}}, target_address,
                    i2c_r != I_IDLE, swing_large, eff_edge, pwr_s};
                CAPTURE_OFS: rdata_nxt = {{(32-WW){1'b0}}, cap_r};
                default: begin
                    rdata_nxt = 32'h0000_0000;
                    rresp_nxt = RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            wr_addr_r <= 4'h0;
            wr_data_r <= 32'h0000_0000;
            wr_strb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (enable) begin
            aw_full_r <= aw_full_nxt;
            w_full_r <= w_full_nxt;
            wr_addr_r <= wa_nxt;
            wr_data_r <= wd_nxt;
            wr_strb_r <= ws_nxt;
            s_axi_bvalid <= bvalid_nxt;
            s_axi_bresp <= bresp_nxt;
            s_axi_rvalid <= rvalid_nxt;
            s_axi_rdata <= rdata_nxt;
            s_axi_rresp <= rresp_nxt;
        end
    end

    // checks
    sequence run_edge_s;
        pwr_l && link_en && edge_l;
    endsequence
    sequence fall_edge_s;
        pwr_l && link_en && !edge_l;
    endsequence
    sequence ack_due_s;
        enable && pwr_s && !i2c_start && !i2c_stop && i2c_r == I_ADDR && scl_fall &&
            bit_r == I2C_ADDR_BITS && addr_hit;
    endsequence

    pd_legs_a: assert property (@(posedge parallel_strobe_in) disable iff (link_rst)
        !pwr_l && link_en |=> serial_p && serial_n && !tx_valid)
        else $error("legs not both high in power-down");
    pd_pll_a: assert property (@(posedge clock) disable iff (reset)
        enable && !pwr_s |=> !pll_enable)
        else $error("pll left on in power-down");
    run_pll_a: assert property (@(posedge clock) disable iff (reset)
        enable && pwr_s |=> pll_enable)
        else $error("pll off while running");
    pd_regs_a: assert property (@(posedge clock) disable iff (reset)
        enable && !pwr_s |=> cfg_r == CFG_RESET)
        else $error("configuration kept through power-down");
    rise_capture_a: assert property (@(posedge parallel_strobe_in) disable iff (link_rst)
        run_edge_s |=> {tx_ctrl, tx_data} == $past({ctrl_in, data_in}) && tx_valid)
        else $error("rising capture wrong");
    fall_capture_a: assert property (@(posedge parallel_strobe_in) disable iff (link_rst)
        fall_edge_s |=> {tx_ctrl, tx_data} == $past(fall_r) && tx_valid)
        else $error("falling capture wrong");
    edge_reg_a: assert property (@(posedge clock) disable iff (reset)
        enable && pwr_s && wr_do && wr_addr_r == CFG_OFS && wr_strb_r[0] &&
            wr_data_r[EDGE_OVR_BIT] |=> eff_edge == $past(wr_data_r[EDGE_VAL_BIT]))
        else $error("edge register not applied");
    swing_a: assert property (@(posedge clock) disable iff (reset)
        enable && cfg_r[SWING_OVR_BIT] ##1 enable |-> swing_large == $past(cfg_r[SWING_VAL_BIT]))
        else $error("swing does not follow register");
    strap_a: assert property (@(posedge clock) disable iff (reset)
        enable && pwr_s && strap_pend_r |=>
            target_address == (STRAP_ADDR_BASE | {{(ADDR_W-STRAP_W){1'b0}}, $past(strap_s)}))
        else $error("strap address not taken");
    sda_ack_a: assert property (@(posedge clock) disable iff (reset)
        ack_due_s |=> config_sda_oe && !config_sda_out)
        else $error("no open-drain acknowledge on address match");
    bresp_hold_a: assert property (@(posedge clock) disable iff (reset)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped before taken");
endmodule : serializer_input_and_power_control

// File: tb/pixel_source.sv
/*
 * model of the parallel video source that feeds the transmitter.
 * assumes the capture logic samples on either strobe edge; the link
 * clock runs free, so it never stops between words.
 */
`timescale 1ns/10ps
module pixel_source
    import ser_link_pkg::*;
(
    output logic strobe,
    output logic [DATA_W-1:0] data,
    output logic [CTRL_W-1:0] ctrl
);
    logic [DATA_W-2:0] cnt; // word counter

    // 64 ns link clock, phase unrelated to the system clock
    initial begin
        strobe = 1'b0;
        cnt = '0;
        data = '0;
        ctrl = '0;
        #7.3; // off the system clock's edges, so bench samples never race
        forever #32 strobe = ~strobe;
    end

    // word a is stable around the falling edge, word b around the rising
    // edge; bit 23 tells which edge captured it
    always @(posedge strobe) begin
        cnt = cnt + 1'b1;
        ctrl <= cnt[4:2]; // holds four words, equal to data bits 4:2
        #16 data = {1'b0, cnt};
        #32 data = {1'b1, cnt};
    end
endmodule : pixel_source

// File: tb/tb_top.sv
/*
 * self-checking bench: axi4-lite register access, pin control,
 * power-down and the two-wire address responder.
 * assumes the pixel_source model drives the link clock and data.
 */
`timescale 1ns/10ps
module tb_top;
    import ser_link_pkg::*;
    logic clock, reset, enable, power_down_n, strobe_edge_select, swing_select;
    logic strobe, config_scl, sda_drv, sda_wire;
    logic [DATA_W-1:0] data_in, tx_data;
    logic [CTRL_W-1:0] ctrl_in, tx_ctrl;
    logic sda_out, sda_oe, serial_p, serial_n, pll_enable, swing_large, tx_valid;
    logic [ADDR_W-1:0] target_address;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, rd;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, ack;
    logic [1:0] bresp, rresp, rs;
    int errors, n_tests;

    // open-drain wire: pull-up, low when either side pulls
    assign sda_wire = sda_drv & (sda_oe ? sda_out : 1'b1);

    pixel_source pixel_source_i (.strobe(strobe), .data(data_in), .ctrl(ctrl_in));

    serializer_input_and_power_control serializer_input_and_power_control_i (
        .clock(clock), .reset(reset), .enable(enable), .power_down_n(power_down_n),
        .strobe_edge_select(strobe_edge_select), .swing_select(swing_select),
        .target_address_strap(3'h5), .parallel_strobe_in(strobe), .data_in(data_in),
        .ctrl_in(ctrl_in), .config_scl(config_scl), .config_sda_in(sda_wire),
        .config_sda_out(sda_out), .config_sda_oe(sda_oe), .serial_p(serial_p),
        .serial_n(serial_n), .pll_enable(pll_enable), .swing_large(swing_large),
        .target_address(target_address), .tx_data(tx_data), .tx_ctrl(tx_ctrl),
        .tx_valid(tx_valid), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    // 100 MHz system clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // one comparison, counted
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // verdict and end of run
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize

    // a wait that ran out of cycles
    task automatic hang(input string name);
        chk(name, 32'h1, 32'h0);
        summarize();
    endtask : hang

    // axi write: address and data offered together, each released when taken
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
        bit aw, w;
        aw = 0;
        w = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 100; n++) begin
            @(posedge clock);
            if (aw && w && bvalid === 1'b1) begin
                bready <= 1'b0;
                chk("bresp", {30'h0, RESP_OKAY}, {30'h0, bresp});
                @(posedge clock);
                return;
            end
            if (!aw && awready === 1'b1) begin
                aw = 1;
                awvalid <= 1'b0;
            end
            if (!w && wready === 1'b1) begin
                w = 1;
                wvalid <= 1'b0;
            end
        end
        hang("write answer");
    endtask : axi_write

    // axi read: returns data and response code
    task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        bit ar;
        ar = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 100; n++) begin
            @(posedge clock);
            if (ar && rvalid === 1'b1) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                @(posedge clock);
                return;
            end
            if (!ar && arready === 1'b1) begin
                ar = 1;
                arvalid <= 1'b0;
            end
        end
        hang("read answer");
    endtask : axi_read

    // wait for the expected edge marker, then check that capture stays on it
    task automatic wait_edge(input logic e);
        for (int n = 0; n < 300 && !(tx_data[23] === e && tx_valid === 1'b1); n++) begin
            @(posedge clock);
        end
        if (tx_data[23] !== e) hang("capture edge");
        repeat (20) @(posedge clock);
        chk("capture edge", {31'h0, e}, {31'h0, tx_data[23]});
        chk("valid", 32'h1, {31'h0, tx_valid});
        chk("ctrl pairing", {29'h0, tx_data[4:2]}, {29'h0, tx_ctrl});
        chk("legs differ", 32'h1, {31'h0, serial_p ^ serial_n});
    endtask : wait_edge

    // two-wire address byte, msb first; reports whether it was acknowledged
    task automatic wire_addr(input logic [7:0] b, output logic acked);
        acked = 1'b0;
        sda_drv <= 1'b0;
        repeat (10) @(posedge clock);
        for (int i = 7; i >= -1; i--) begin
            config_scl <= 1'b0;
            repeat (5) @(posedge clock);
            sda_drv <= (i >= 0) ? b[i] : 1'b1;
            repeat (5) @(posedge clock);
            config_scl <= 1'b1;
            repeat (10) @(posedge clock);
            if (i < 0 && sda_wire === 1'b0) acked = 1'b1;
        end
        config_scl <= 1'b0;
        sda_drv <= 1'b0;
        repeat (10) @(posedge clock);
        config_scl <= 1'b1;
        repeat (10) @(posedge clock);
        sda_drv <= 1'b1;
        repeat (10) @(posedge clock);
    endtask : wire_addr

    // main sequence
    initial begin
        errors = 0;
        n_tests = 0;
        reset = 1'b1;
        enable = 1'b1;
        power_down_n = 1'b1;
        strobe_edge_select = 1'b1;
        swing_select = 1'b0;
        config_scl = 1'b1;
        sda_drv = 1'b1;
        {awaddr, araddr, wdata, wstrb} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        repeat (8) @(posedge clock);
        chk("pll", 32'h1, {31'h0, pll_enable});
        chk("address", 32'h2d, {25'h0, target_address});
        wait_edge(1'b1);
        strobe_edge_select <= 1'b0;
        wait_edge(1'b0);
        wstrb <= 4'h1;
        axi_write(CFG_OFS, 32'h3);
        wait_edge(1'b1);
        swing_select <= 1'b1;
        repeat (8) @(posedge clock);
        chk("swing pin", 32'h1, {31'h0, swing_large});
        axi_write(CFG_OFS, 32'h7);
        repeat (8) @(posedge clock);
        chk("swing reg", 32'h0, {31'h0, swing_large});
        axi_read(CFG_OFS, rd, rs);
        chk("cfg", 32'h7, rd);
        axi_read(CAPTURE_OFS, rd, rs);
        chk("capture marker", 32'h1, {31'h0, rd[23]});
        chk("capture ctrl", {29'h0, rd[4:2]}, {29'h0, rd[26:24]});
        axi_read(4'hc, rd, rs);
        chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
        chk("unmapped data", 32'h0, rd);
        enable <= 1'b0;
        power_down_n <= 1'b0;
        repeat (8) @(posedge clock);
        chk("frozen pll", 32'h1, {31'h0, pll_enable});
        enable <= 1'b1;
        for (int n = 0; n < 200 && !(serial_p === 1'b1 && serial_n === 1'b1); n++) begin
            @(posedge clock);
        end
        if (!(serial_p === 1'b1 && serial_n === 1'b1)) hang("legs high");
        chk("legs", 32'h3, {30'h0, serial_p, serial_n});
        chk("pll off", 32'h0, {31'h0, pll_enable});
        chk("valid off", 32'h0, {31'h0, tx_valid});
        power_down_n <= 1'b1;
        repeat (8) @(posedge clock);
        axi_read(CFG_OFS, rd, rs);
        chk("cfg cleared", {28'h0, CFG_RESET}, rd);
        chk("swing after", 32'h1, {31'h0, swing_large});
        wait_edge(1'b0);
        axi_read(STATUS_OFS, rd, rs);
        chk("status", 32'h2d5, rd);
        wire_addr(8'h5a, ack);
        chk("ack own", 32'h1, {31'h0, ack});
        chk("sda out", 32'h0, {31'h0, sda_out});
        wire_addr(8'h5c, ack);
        chk("ack other", 32'h0, {31'h0, ack});
        summarize();
    end
endmodule : tb_top
